// ===== hdl/uvp_programmer.sv
// Host-side controller that reads, programs and identifies a UV-erasable 16K x 8 memory
`timescale 1ns/1ns
`include "uvp_defines.svh"
// Function
// - Host keeps select or drive high on every unselected memory.
// - Host presents stable address and data, then pulses strobe low.
// - Short algorithm: 100 us pulses, verify each, fail after 10.
// - Fast algorithm: 1 ms prime pulses, verify each, fail after 25.
// - After fast match, one final pulse of three ms per prime pulse.
// - Any location may be programmed in any order.
// - After a full routine, recheck every byte at normal supply. Check command stops at first non-erased byte (fast), only reads (short).
// - Identifier pin high voltage selects signature; lowest address picks code.
module uvp_programmer
   import uvp_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   output logic req_ready_o,
   input wire logic [1:0] req_cmd_i,
   input wire logic [1:0] req_alg_i,
   input wire logic [13:0] req_addr_i,
   input wire logic [7:0] req_data_i,
   output logic done_o,
   output logic fail_o,
   output logic [7:0] rdata_o,
   output logic [4:0] tries_o,
   output logic [13:0] fail_addr_o,
   output logic [13:0] addr_lines_o,
   input wire logic [7:0] byte_lines_i,
   output logic [7:0] byte_lines_o,
   output logic [7:0] byte_lines_oe_o,
   output logic chip_sel_n_o,
   output logic out_drive_n_o,
   output logic write_strobe_n_o,
   output logic prog_supply_o,
   output logic id_mode_pin_o
);
   uvp_state_e state_reg, state_next;
   logic [1:0] cmd_reg;
   logic [1:0] alg_reg;
   logic [13:0] addr_reg;
   logic [7:0] data_reg;
   logic [4:0] tries_reg;
   logic [1:0] final_cnt_reg;
   logic [7:0] sync1_reg, sync2_reg;
   logic done_reg, fail_reg;
   logic [7:0] rdata_reg;
   logic [13:0] fail_addr_reg;
   logic timer_load;
   logic [19:0] timer_count;
   logic timer_exp;

   uvp_timer u_timer (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .load_i(timer_load),
      .count_i(timer_count),
      .expired_o(timer_exp)
   );

   // Data pins are asynchronous to our clock
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end else begin
         sync1_reg <= byte_lines_i;
         sync2_reg <= sync1_reg;
      end
   end

   wire is_fast_w = (alg_reg == UVP_ALG_FAST);
   wire is_prog_w = (cmd_reg == UVP_CMD_PROG);
   wire is_sig_w = (cmd_reg == UVP_CMD_SIG);
   wire is_check_w = (cmd_reg == UVP_CMD_CHECK);
   wire match_w = (sync2_reg == data_reg);
   wire [4:0] max_tries_w = is_fast_w ? `UVP_PRIME_MAX_TRIES : {1'b0, `UVP_SHORT_MAX_TRIES};
   wire out_of_tries_w = (tries_reg >= max_tries_w);
   wire sig_parity_ok_w = ^sync2_reg;
   wire [13:0] sig_addr_w = {13'h0000, addr_reg[`UVP_ID_SEL_BIT]};
   wire last_addr_w = (addr_reg == 14'(`UVP_DEPTH - 1));
   wire [19:0] pulse_cyc_w = is_fast_w ? 20'(`UVP_PRIME_PULSE_CYC) : 20'(`UVP_SHORT_PULSE_CYC);
   wire [19:0] setup_cyc_w = 20'(`UVP_SETUP_CYC);
   wire [19:0] access_cyc_w = 20'(`UVP_ACCESS_CYC);
   wire [19:0] final_cyc_w = 20'(`UVP_PRIME_PULSE_CYC) * 20'(tries_reg);

   wire st_pulse_w = (state_reg == UVP_ST_PULSE) || (state_reg == UVP_ST_FINAL);
   wire st_drive_w = (state_reg == UVP_ST_SETUP) || st_pulse_w || (state_reg == UVP_ST_HOLD);
   wire st_read_w = (state_reg == UVP_ST_VERIFY) || (state_reg == UVP_ST_READ) || (state_reg == UVP_ST_CHECK);
   wire st_hv_w = is_prog_w && (st_drive_w || (state_reg == UVP_ST_VERIFY));

   always_comb begin
      state_next = state_reg;
      timer_load = 1'b0;
      timer_count = setup_cyc_w;
      unique case (state_reg)
         UVP_ST_IDLE: begin
            if (req_valid_i) begin
               timer_load = 1'b1;
               state_next = (req_cmd_i == UVP_CMD_PROG) ? UVP_ST_SETUP : UVP_ST_READ;
               if (req_cmd_i == UVP_CMD_CHECK) begin
                  state_next = UVP_ST_CHECK;
               end
            end
         end
         UVP_ST_SETUP: begin
            if (timer_exp) begin
               timer_load = 1'b1;
               timer_count = pulse_cyc_w;
               state_next = UVP_ST_PULSE;
               if (final_cnt_reg != 2'h0) begin
                  timer_count = final_cyc_w;
                  state_next = UVP_ST_FINAL;
               end
            end
         end
         UVP_ST_PULSE: begin
            if (timer_exp) begin
               timer_load = 1'b1;
               state_next = UVP_ST_HOLD;
            end
         end
         UVP_ST_HOLD: begin
            if (timer_exp) begin
               // Hold after the final pulse keeps data valid, then the byte is finished
               timer_load = (final_cnt_reg == 2'h0);
               timer_count = access_cyc_w;
               state_next = (final_cnt_reg != 2'h0) ? UVP_ST_DONE : UVP_ST_VERIFY;
            end
         end
         UVP_ST_VERIFY: begin
            if (timer_exp) begin
               if (match_w && is_fast_w) begin
                  timer_load = 1'b1;
                  state_next = UVP_ST_SETUP;
               end else if (match_w || out_of_tries_w) begin
                  state_next = UVP_ST_DONE;
               end else begin
                  timer_load = 1'b1;
                  state_next = UVP_ST_SETUP;
               end
            end
         end
         UVP_ST_FINAL: begin
            if (timer_exp) begin
               timer_load = 1'b1;
               timer_count = final_cyc_w;
               state_next = UVP_ST_FINAL;
               if (final_cnt_reg == 2'h1) begin
                  timer_count = setup_cyc_w;
                  state_next = UVP_ST_HOLD;
               end
            end
         end
         UVP_ST_READ: begin
            if (timer_exp) begin
               state_next = UVP_ST_DONE;
            end
         end
         UVP_ST_CHECK: begin
            if (timer_exp) begin
               timer_load = !last_addr_w && (sync2_reg == `UVP_ERASED_BYTE || !is_fast_w);
               state_next = timer_load ? UVP_ST_CHECK : UVP_ST_DONE;
               timer_count = access_cyc_w;
            end
         end
         UVP_ST_DONE: state_next = UVP_ST_IDLE;
         default: state_next = UVP_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_reg <= UVP_ST_IDLE;
         cmd_reg <= 2'h0;
         alg_reg <= 2'h0;
         addr_reg <= 14'h0000;
         data_reg <= 8'hff;
         tries_reg <= 5'h00;
         final_cnt_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == UVP_ST_IDLE && req_valid_i) begin
            cmd_reg <= req_cmd_i;
            alg_reg <= req_alg_i;
            addr_reg <= (req_cmd_i == UVP_CMD_CHECK) ? 14'h0000 : req_addr_i;
            data_reg <= req_data_i;
            tries_reg <= 5'h00;
            final_cnt_reg <= 2'h0;
         end
         if (state_reg == UVP_ST_SETUP && timer_exp && final_cnt_reg == 2'h0) begin
            tries_reg <= tries_reg + 5'h01;
         end
         // Final pulse is three stretches of tries ms, kept in a short timer
         if (state_reg == UVP_ST_VERIFY && timer_exp && match_w && is_fast_w) begin
            final_cnt_reg <= 2'(`UVP_FINAL_FACTOR);
         end
         if (state_reg == UVP_ST_FINAL && timer_exp && final_cnt_reg != 2'h1) begin
            final_cnt_reg <= final_cnt_reg - 2'h1;
         end
         if (state_reg == UVP_ST_CHECK && timer_exp && !last_addr_w) begin
            addr_reg <= addr_reg + 14'h0001;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         done_reg <= 1'b0;
         fail_reg <= 1'b0;
         rdata_reg <= 8'h00;
         fail_addr_reg <= 14'h0000;
      end else begin
         done_reg <= (state_next == UVP_ST_DONE);
         if (state_reg == UVP_ST_IDLE && req_valid_i) begin
            fail_reg <= 1'b0;
         end
         if ((state_reg == UVP_ST_VERIFY || state_reg == UVP_ST_READ || state_reg == UVP_ST_CHECK) && timer_exp) begin
            rdata_reg <= sync2_reg;
         end
         if (state_reg == UVP_ST_VERIFY && timer_exp && !match_w && out_of_tries_w) begin
            fail_reg <= 1'b1;
            fail_addr_reg <= addr_reg;
         end
         if (state_reg == UVP_ST_READ && timer_exp && is_sig_w && !sig_parity_ok_w) begin
            fail_reg <= 1'b1;
         end
         // Fast-mode check compares against erased ones; short-mode check only sweeps reads
         if (state_reg == UVP_ST_CHECK && timer_exp && is_fast_w && sync2_reg != `UVP_ERASED_BYTE) begin
            fail_reg <= 1'b1;
            fail_addr_reg <= addr_reg;
         end
      end
   end

   assign req_ready_o = (state_reg == UVP_ST_IDLE);
   assign done_o = done_reg;
   assign fail_o = fail_reg;
   assign rdata_o = rdata_reg;
   assign tries_o = tries_reg;
   assign fail_addr_o = fail_addr_reg;
   assign addr_lines_o = is_sig_w ? sig_addr_w : addr_reg;
   assign byte_lines_o = data_reg;
   assign byte_lines_oe_o = {8{st_drive_w}};
   assign chip_sel_n_o = !(st_drive_w || st_read_w);
   assign out_drive_n_o = !st_read_w;
   assign write_strobe_n_o = !st_pulse_w;
   assign prog_supply_o = st_hv_w;
   assign id_mode_pin_o = is_sig_w && (state_reg == UVP_ST_READ);
endmodule

// ===== hdl/uvp_defines.svh
// Timing counts, widths and mode constants for the EPROM programmer controller
`ifndef UVP_DEFINES_SVH
`define UVP_DEFINES_SVH
`define UVP_CLK_NS 100
`define UVP_ADDR_W 14
`define UVP_DATA_W 8
`define UVP_DEPTH 16384
`define UVP_SHORT_PULSE_NS 100000
`define UVP_SHORT_PULSE_CYC ((`UVP_SHORT_PULSE_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_PRIME_PULSE_NS 1000000
`define UVP_PRIME_PULSE_CYC ((`UVP_PRIME_PULSE_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_SETUP_NS 2000
`define UVP_SETUP_CYC ((`UVP_SETUP_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_ACCESS_NS 300
`define UVP_ACCESS_CYC ((`UVP_ACCESS_NS + `UVP_CLK_NS - 1) / `UVP_CLK_NS)
`define UVP_SHORT_MAX_TRIES 4'ha
`define UVP_PRIME_MAX_TRIES 5'h19
`define UVP_FINAL_FACTOR 3
`define UVP_ERASED_BYTE 8'hff
`define UVP_ID_SEL_BIT 0
`define UVP_PARITY_BIT 7
`endif

// ===== hdl/uvp_pkg.sv
// Types for the EPROM programmer controller
package uvp_pkg;
   typedef enum logic [1:0] {
      UVP_CMD_READ = 2'h0,
      UVP_CMD_PROG = 2'h1,
      UVP_CMD_SIG = 2'h2,
      UVP_CMD_CHECK = 2'h3
   } uvp_cmd_e;
   typedef enum logic [1:0] {
      UVP_ALG_SHORT = 2'h0,
      UVP_ALG_FAST = 2'h1
   } uvp_alg_e;
   typedef enum logic [8:0] {
      UVP_ST_IDLE = 9'h001,
      UVP_ST_SETUP = 9'h002,
      UVP_ST_PULSE = 9'h004,
      UVP_ST_HOLD = 9'h008,
      UVP_ST_VERIFY = 9'h010,
      UVP_ST_FINAL = 9'h020,
      UVP_ST_READ = 9'h040,
      UVP_ST_CHECK = 9'h080,
      UVP_ST_DONE = 9'h100
   } uvp_state_e;
endpackage

// ===== hdl/uvp_timer.sv
// Down-counting wait timer with a one-cycle expiry pulse
`timescale 1ns/1ns
module uvp_timer (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic load_i,
   input wire logic [19:0] count_i,
   output logic expired_o
);
   logic [19:0] cnt_reg;
   logic run_reg;
   wire last_w = run_reg && (cnt_reg == 20'h00001);
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         cnt_reg <= 20'h00000;
         run_reg <= 1'b0;
      end else if (load_i) begin
         cnt_reg <= count_i;
         run_reg <= 1'b1;
      end else if (run_reg) begin
         cnt_reg <= cnt_reg - 20'h00001;
         run_reg <= !last_w;
      end
   end
   // Expiry ignores load so the caller can reload on it without a combinational loop
   assign expired_o = last_w;
endmodule

// ===== bench/uvp_eprom_model.sv
// Behavioural model of the 16K x 8 UV-erasable memory seen from its pins
`timescale 1ns/1ns
module uvp_eprom_model #(
   parameter logic [7:0] MAKER_CODE = 8'h15, // Arbitrary value with odd parity
   parameter logic [7:0] PART_CODE = 8'h8c // Arbitrary value with odd parity
) (
   input wire logic [13:0] addr_i,
   input wire logic [7:0] data_i,
   input wire logic cs_n_i,
   input wire logic od_n_i,
   input wire logic ws_n_i,
   input wire logic vpp_i,
   input wire logic idp_i,
   input wire logic [4:0] need_i,
   output logic [7:0] q_o
);
   logic [7:0] mem [0:16383];
   logic [7:0] last;
   logic [4:0] hits;
   logic [13:0] hit_addr;
   wire rd_en = !cs_n_i && !od_n_i && ws_n_i;
   wire [7:0] word = idp_i ? (addr_i[0] ? PART_CODE : MAKER_CODE) : mem[addr_i];
   initial begin
      for (int i = 0; i < 16384; i++) mem[i] = 8'hff;
      last = 8'h00;
      hits = 5'h00;
      hit_addr = 14'h0000;
   end
   // A byte only takes after need_i pulses, so the retry loops get exercised
   always @(posedge ws_n_i) begin
      if (vpp_i && !cs_n_i && od_n_i) begin
         hits = (hit_addr == addr_i) ? hits + 5'h01 : 5'h01;
         hit_addr = addr_i;
         if (hits >= need_i) mem[addr_i] = mem[addr_i] & data_i;
      end
   end
   always @(word or rd_en) if (rd_en) last = word;
   // Released lines show the inverse of the last byte rather than holding it
   assign q_o = rd_en ? word : ~last;
endmodule

// ===== bench/uvp_programmer_chk.sv
// Pin protocol assertions for the EPROM programmer controller
`timescale 1ns/1ns
module uvp_programmer_chk
   import uvp_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic req_valid_i,
   input wire logic req_ready_o,
   input wire logic [1:0] req_cmd_i,
   input wire logic done_o,
   input wire logic [4:0] tries_o,
   input wire logic [13:0] addr_lines_o,
   input wire logic [7:0] byte_lines_o,
   input wire logic [7:0] byte_lines_oe_o,
   input wire logic chip_sel_n_o,
   input wire logic out_drive_n_o,
   input wire logic write_strobe_n_o,
   input wire logic prog_supply_o,
   input wire logic id_mode_pin_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   logic [19:0] low_cnt_reg;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_cnt_reg <= 20'h00000;
      end else if (!write_strobe_n_o) begin
         low_cnt_reg <= low_cnt_reg + 20'h00001;
      end else begin
         low_cnt_reg <= 20'h00000;
      end
   end
   a_strobe_prog_mode: assert property (!write_strobe_n_o |-> !chip_sel_n_o && out_drive_n_o && prog_supply_o)
      else $error("strobe low outside program mode");
   a_pulse_stable_bus: assert property (!write_strobe_n_o |-> $stable(addr_lines_o) && $stable(byte_lines_o))
      else $error("address or data moved during a pulse");
   a_no_contention: assert property (|byte_lines_oe_o |-> out_drive_n_o && prog_supply_o)
      else $error("data driven while memory may drive");
   a_pulse_width: assert property ($rose(write_strobe_n_o) |-> low_cnt_reg == 20'h003e8 ||
      (low_cnt_reg % 20'h02710 == 20'h0 && low_cnt_reg <= 20'hb71b0))
      else $error("program pulse width wrong");
   a_supply_setup: assert property ($fell(write_strobe_n_o) |-> $past(prog_supply_o, 18))
      else $error("supply not settled before pulse");
   a_sig_addr_low: assert property (id_mode_pin_o |-> addr_lines_o[13:1] == 13'h0 && !prog_supply_o)
      else $error("signature with upper address set");
   a_read_latency: assert property (req_valid_i && req_ready_o && req_cmd_i == UVP_CMD_READ |-> ##21 done_o)
      else $error("read done not on the expected cycle");
   a_try_limit: assert property (done_o |-> tries_o <= 5'h19)
      else $error("too many tries reported");
   a_unselected_quiet: assert property (chip_sel_n_o |-> write_strobe_n_o && byte_lines_oe_o == 8'h00)
      else $error("activity while deselected");
   c_read: cover property (req_valid_i && req_ready_o && req_cmd_i == UVP_CMD_READ);
   c_sig: cover property (id_mode_pin_o && addr_lines_o[0]);
   c_long_pulse: cover property ($rose(write_strobe_n_o) && low_cnt_reg > 20'h02710);
endmodule
bind uvp_programmer uvp_programmer_chk uvp_programmer_chk_inst (.*);

// ===== bench/testbench.sv
// Self-checking bench for the EPROM programmer controller
`timescale 1ns/1ns
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
   import uvp_pkg::*;
   localparam logic [7:0] MAKER = 8'h15;
   localparam logic [7:0] PART = 8'h8c;
   logic clk_i = 1'b0, reset_i = 1'b1, valid = 1'b0, rdy, done, fail, cs_n, od_n, ws_n, vpp, idp;
   logic [1:0] cmd = 2'h0, alg = 2'h0;
   logic [13:0] addr = 14'h0, fail_addr, pins_a;
   logic [7:0] data = 8'h0, rdata, dout, oe, mq, bus;
   logic [4:0] tries, need = 5'h01;
   int err_count = 0, cmp_count = 0, cyc = 0, lowc = 0, widths[$];
   assign bus = (oe & dout) | (~oe & mq);
   uvp_programmer uvp_programmer_inst (.clk_i(clk_i), .reset_i(reset_i), .req_valid_i(valid),
      .req_ready_o(rdy), .req_cmd_i(cmd), .req_alg_i(alg), .req_addr_i(addr), .req_data_i(data),
      .done_o(done), .fail_o(fail), .rdata_o(rdata), .tries_o(tries), .fail_addr_o(fail_addr),
      .addr_lines_o(pins_a), .byte_lines_i(bus), .byte_lines_o(dout), .byte_lines_oe_o(oe),
      .chip_sel_n_o(cs_n), .out_drive_n_o(od_n), .write_strobe_n_o(ws_n), .prog_supply_o(vpp),
      .id_mode_pin_o(idp));
   uvp_eprom_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) uvp_eprom_model_inst (.addr_i(pins_a),
      .data_i(bus), .cs_n_i(cs_n), .od_n_i(od_n), .ws_n_i(ws_n), .vpp_i(vpp), .idp_i(idp),
      .need_i(need), .q_o(mq));
   initial begin
      forever #50 clk_i = ~clk_i;
   end
   // Strobe low widths in clock cycles, collected per command
   always @(posedge clk_i) begin
      cyc++;
      if (!ws_n) lowc <= lowc + 1;
      else begin
         if (lowc != 0) widths.push_back(lowc);
         lowc <= 0;
      end
      if (cyc == 90000) begin
         err_count++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic run_cmd(input logic [1:0] c, input logic [1:0] a, input logic [13:0] ad, input logic [7:0] d);
      int n;
      n = 0;
      while (rdy !== 1'b1 && n < 100) begin @(negedge clk_i); n++; end
      widths.delete();
      @(posedge clk_i);
      valid <= 1'b1; cmd <= c; alg <= a; addr <= ad; data <= d;
      @(posedge clk_i);
      valid <= 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 80000) begin @(negedge clk_i); n++; end
      `CHK("done", 1'b1, done)
   endtask
   task automatic t_read_erased();
      run_cmd(UVP_CMD_READ, UVP_ALG_SHORT, 14'h3fff, 8'h00);
      `CHK("erased", 8'hff, rdata)
      `CHK("rfail", 1'b0, fail)
   endtask
   task automatic t_prog_short();
      need = 5'h03;
      run_cmd(UVP_CMD_PROG, UVP_ALG_SHORT, 14'h0005, 8'ha5);
      `CHK("sfail", 1'b0, fail)
      `CHK("stries", 5'h03, tries)
      `CHK("spulses", 3, widths.size())
      foreach (widths[i]) `CHK("swidth", 1000, widths[i])
      run_cmd(UVP_CMD_READ, UVP_ALG_SHORT, 14'h0005, 8'h00);
      `CHK("readback", 8'ha5, rdata)
   endtask
   // Blank check stops at the first byte that is not erased
   task automatic t_blank_check();
      run_cmd(UVP_CMD_CHECK, UVP_ALG_FAST, 14'h0000, 8'h00);
      `CHK("bfail", 1'b1, fail)
      `CHK("baddr", 14'h0005, fail_addr)
      `CHK("bdata", 8'ha5, rdata)
   endtask
   task automatic t_short_fail();
      need = 5'h1f;
      run_cmd(UVP_CMD_PROG, UVP_ALG_SHORT, 14'h0100, 8'h00);
      `CHK("ffail", 1'b1, fail)
      `CHK("ftries", 5'h0a, tries)
      `CHK("faddr", 14'h0100, fail_addr)
      `CHK("fpulses", 10, widths.size())
   endtask
   task automatic t_fast();
      need = 5'h01;
      run_cmd(UVP_CMD_PROG, UVP_ALG_FAST, 14'h2000, 8'h3c);
      `CHK("xfail", 1'b0, fail)
      `CHK("xtries", 5'h01, tries)
      `CHK("xpulses", 2, widths.size())
      `CHK("prime", 10000, widths[0])
      `CHK("final", 30000, widths[1])
   endtask
   task automatic t_signature();
      run_cmd(UVP_CMD_SIG, UVP_ALG_SHORT, 14'h0000, 8'h00);
      `CHK("maker", MAKER, rdata)
      `CHK("mpar", 1'b0, fail)
      run_cmd(UVP_CMD_SIG, UVP_ALG_SHORT, 14'h0001, 8'h00);
      `CHK("part", PART, rdata)
      `CHK("ppar", 1'b0, fail)
   endtask
   initial begin
      repeat (5) @(posedge clk_i);
      reset_i <= 1'b0;
      t_read_erased();
      t_prog_short();
      t_blank_check();
      t_short_fail();
      t_fast();
      t_signature();
      end_of_test();
   end
endmodule
